// *** hdl/fcp_pkg.sv ***
// Purpose: Shared constants and types for the flash command host.
// Assumes: 250 MHz ref_clk, byte-wide flash, AHB-Lite register port.
// Notes:   All offsets, fields and timings are named here once.
package fcp_pkg;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int WAKE_READ_NS    = 400;
  localparam int WAKE_READ_CYC   = (WAKE_READ_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int WAKE_WRITE_NS   = 1000;
  localparam int WAKE_WRITE_CYC  = (WAKE_WRITE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int BUS_CYCLE_NS    = 120;
  localparam int BUS_CYCLE_CYC   = (BUS_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int CNT_W           = 16;

  // --------------------------------------------------------------------
  // Flash command bytes and status bit positions
  // --------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BYTE_WRITE   = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;
  localparam int SR_READY   = 7;
  localparam int SR_ERASE   = 5;
  localparam int SR_WRITE   = 4;
  localparam int SR_SUPPLY  = 3;

  // --------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ    = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_PD    = 4;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_W      = 2;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ERASE, OP_CLEAR, OP_RESET, OP_STATUS
  } fcp_op_t;

  // Flash pin bundle driven by the host.
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_powerdown_n;
    logic [19:0] addr;
  } fcp_pins_t;
endpackage

// *** hdl/fcp_host.sv ***
// Purpose: Host controller driving a byte-wide flash through its pins.
// Assumes: Flash inputs synchronous to ref_clk; one AHB-Lite master.
// Notes:   Software starts one operation at a time through CTRL.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fcp_host #(
  parameter int WAKE_RD = fcp_pkg::WAKE_READ_CYC,
  parameter int WAKE_WR = fcp_pkg::WAKE_WRITE_CYC,
  parameter int BUS_CYC = fcp_pkg::BUS_CYCLE_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output fcp_pkg::fcp_pins_t      pins,
  input  wire logic [7:0]         dq_in,
  output logic [7:0]              dq_out,
  output logic                    dq_oe,
  input  wire logic               ready_busy,
  output logic                    irq
);
  // --------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------
  typedef enum {S_IDLE, S_WAKE, S_CMD, S_DATA, S_POLL, S_RDSR, S_CHECK,
                S_FIN, S_RDARR, S_DONE} fcp_state_t;
  fcp_state_t  state_q;
  logic        wr_ph_q;
  logic [7:0]  wa_q;
  logic        go_q;
  fcp_pkg::fcp_op_t op_q;
  logic        pd_q;
  logic [19:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  sr_q;
  logic [fcp_pkg::IRQ_W-1:0] irq_q;
  logic [fcp_pkg::IRQ_W-1:0] mask_q;
  logic [fcp_pkg::IRQ_W-1:0] ev;
  logic        rd_irq;
  logic        setup;
  logic        busy;

  assign setup     = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Busy covers the go pulse too, so a CTRL read right after GO sees it.
  assign busy      = (state_q != S_IDLE) || go_q;
  assign rd_irq    = setup && !hwrite && haddr[7:0] == fcp_pkg::REG_IRQ;

  // Write data phase lands one cycle after the address phase.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ph_q <= 1'b0;
      wa_q    <= 8'h00;
      go_q    <= 1'b0;
      op_q    <= fcp_pkg::OP_READ;
      pd_q    <= 1'b0;
      addr_q  <= 20'h00000;
      data_q  <= 8'h00;
      mask_q  <= '0;
    end else begin
      wr_ph_q <= setup && hwrite;
      wa_q    <= haddr[7:0];
      go_q    <= 1'b0;
      if (wr_ph_q) begin
        case (wa_q)
          fcp_pkg::REG_CTRL: begin
            go_q <= hwdata[fcp_pkg::CTRL_GO] && !busy;
            if (!busy) begin
              op_q <= fcp_pkg::fcp_op_t'(hwdata[fcp_pkg::CTRL_OP_LO +: 3]);
              pd_q <= hwdata[fcp_pkg::CTRL_PD];
            end
          end
          fcp_pkg::REG_ADDR: addr_q <= hwdata[19:0];
          fcp_pkg::REG_DATA: data_q <= hwdata[7:0];
          fcp_pkg::REG_MASK: mask_q <= hwdata[fcp_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Read data registered in the data phase; unmapped reads give zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (setup && !hwrite) begin
      case (haddr[7:0])
        fcp_pkg::REG_CTRL:   hrdata <= {27'h0, pd_q, 3'h0, busy};
        fcp_pkg::REG_ADDR:   hrdata <= {12'h000, addr_q};
        fcp_pkg::REG_DATA:   hrdata <= {24'h000000, data_q};
        fcp_pkg::REG_STATUS: hrdata <= {24'h000000, sr_q};
        fcp_pkg::REG_IRQ:    hrdata <= {30'h0, irq_q};
        fcp_pkg::REG_MASK:   hrdata <= {30'h0, mask_q};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  // Sticky events; a new event beats the read-clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_q <= '0;
    end else begin
      irq_q <= (rd_irq ? '0 : irq_q) | ev;
    end
  end
  assign irq = |(irq_q & mask_q);

  // --------------------------------------------------------------------
  // Flash sequencer
  // --------------------------------------------------------------------
  logic [fcp_pkg::CNT_W-1:0] cnt_q;
  logic        second_q;
  logic        strobe;
  logic [7:0]  byte_out;
  logic        cnt_zero;
  assign cnt_zero = (cnt_q == '0);

  // Command byte for first and second bus write of each operation.
  always_comb begin
    byte_out = fcp_pkg::CMD_READ_ARRAY;
    case (op_q)
      fcp_pkg::OP_WRITE:
        byte_out = second_q ? data_q : fcp_pkg::CMD_BYTE_WRITE;
      fcp_pkg::OP_ERASE:
        byte_out = second_q ? fcp_pkg::CMD_ERASE_CONF
                            : fcp_pkg::CMD_ERASE_SETUP;
      fcp_pkg::OP_CLEAR:  byte_out = fcp_pkg::CMD_CLEAR_STATUS;
      fcp_pkg::OP_STATUS: byte_out = fcp_pkg::CMD_READ_STATUS;
      default:            byte_out = fcp_pkg::CMD_READ_ARRAY;
    endcase
  end

  assign ev[fcp_pkg::IRQ_DONE] = (state_q == S_DONE);
  // Only jobs that read the device status may raise an error; an array
  // byte or a stale status word would give false alarms.
  assign ev[fcp_pkg::IRQ_ERR]  = (state_q == S_DONE) && !pd_q &&
    (op_q == fcp_pkg::OP_WRITE || op_q == fcp_pkg::OP_ERASE ||
     op_q == fcp_pkg::OP_STATUS) &&
    (sr_q[fcp_pkg::SR_SUPPLY] || sr_q[fcp_pkg::SR_WRITE] ||
     sr_q[fcp_pkg::SR_ERASE]);

  // Each bus phase lasts BUS_CYC+1 cycles; the counter also times wake-up.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q  <= S_IDLE;
      cnt_q    <= '0;
      second_q <= 1'b0;
      sr_q     <= 8'h80;
    end else begin
      if (!cnt_zero)
        cnt_q <= cnt_q - 1'b1;
      case (state_q)
        S_IDLE: if (go_q) begin
          second_q <= 1'b0;       // Each go sends the full sequence.
          if (pd_q) begin
            state_q <= S_DONE;    // Stays in powerdown until a later go.
          end else if (!pins.reset_powerdown_n) begin
            // Wait the longer of the two wake delays before any strobe.
            cnt_q   <= fcp_pkg::CNT_W'((WAKE_WR > WAKE_RD) ?
                                       WAKE_WR : WAKE_RD);
            state_q <= S_WAKE;
          end else if (op_q == fcp_pkg::OP_READ) begin
            cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
            state_q <= S_RDARR;
          end else begin
            cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
            state_q <= S_CMD;
          end
        end
        S_WAKE: if (cnt_zero) begin
          sr_q    <= 8'h80;       // Device status restarts after powerdown.
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= (op_q == fcp_pkg::OP_READ) ? S_RDARR : S_CMD;
        end
        S_CMD: if (cnt_zero) begin
          cnt_q <= fcp_pkg::CNT_W'(BUS_CYC);
          if (!second_q && (op_q == fcp_pkg::OP_WRITE ||
                            op_q == fcp_pkg::OP_ERASE)) begin
            second_q <= 1'b1;
            state_q  <= S_DATA;
          end else if (second_q) begin
            state_q <= S_POLL;    // The pair is in; wait for the job.
          end else if (op_q == fcp_pkg::OP_STATUS) begin
            state_q <= S_RDSR;
          end else begin
            state_q <= S_FIN;
          end
        end
        S_DATA: if (cnt_zero) begin   // Recovery gap between writes.
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= S_CMD;       // Second write of the pair follows.
        end
        S_POLL: if (ready_busy && cnt_zero) begin
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= S_RDSR;
        end
        S_RDSR: if (cnt_zero) begin
          sr_q    <= dq_in;       // Status latched at end of read strobe.
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= S_CHECK;
        end
        S_CHECK: if (cnt_zero) begin
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= (op_q == fcp_pkg::OP_STATUS) ? S_DONE : S_FIN;
        end
        S_FIN: if (cnt_zero) begin    // Return to array reads.
          cnt_q   <= fcp_pkg::CNT_W'(BUS_CYC);
          state_q <= S_RDARR;
        end
        S_RDARR: if (cnt_zero) begin
          if (op_q == fcp_pkg::OP_READ)
            sr_q <= dq_in;        // Array byte shown in STATUS for reads.
          state_q <= S_DONE;
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Strobe low for the first half of each write phase.
  assign strobe = (cnt_q > fcp_pkg::CNT_W'(BUS_CYC / 2));

  // Pins come from flops so the flash never sees a combinational glitch.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pins   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  reset_powerdown_n: 1'b0, addr: 20'h00000};
      dq_out <= 8'h00;
      dq_oe  <= 1'b1;
    end else begin
      pins.addr <= addr_q;
      pins.reset_powerdown_n <= !(pd_q && state_q == S_DONE) &&
        (pins.reset_powerdown_n || state_q == S_WAKE);
      // Both strobe and select low only inside a write phase.
      pins.we_n <= !((state_q == S_CMD || state_q == S_FIN) &&
                     strobe);
      pins.ce_n <= !(state_q == S_CMD || state_q == S_FIN ||
                     state_q == S_RDSR || state_q == S_RDARR);
      pins.oe_n <= !(state_q == S_RDSR || state_q == S_RDARR);
      dq_out    <= (state_q == S_FIN) ? fcp_pkg::CMD_READ_ARRAY
                                      : byte_out;
      dq_oe     <= !(state_q == S_CMD || state_q == S_FIN);
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  wr_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pins.we_n |-> !pins.ce_n && !dq_oe)
    else $error("write strobe without select or data drive");
  wake_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pins.reset_powerdown_n) |-> pins.we_n [*8])
    else $error("write too soon after wake");
  pd_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pins.reset_powerdown_n |-> pins.we_n && pins.oe_n)
    else $error("strobe during powerdown");
  final_ff_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_FIN |=> state_q == S_FIN || state_q == S_RDARR)
    else $error("read array step skipped");
  wake_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_WAKE |-> pins.we_n && pins.oe_n && pins.ce_n)
    else $error("flash strobed during wake delay");
  fin_ff_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pins.we_n && $past(state_q) == S_FIN |->
      dq_out == fcp_pkg::CMD_READ_ARRAY)
    else $error("closing write is not read array");
endmodule

// *** sim/fcp_flash_model.sv ***
// Purpose: Behavioural byte-wide flash seen from the host's pins.
// Assumes: Pins are sampled on ref_clk; sixteen bytes stand for the array.
// Notes:   A released data bus toggles every cycle so stale data is seen.
`timescale 1ns/1ps
module fcp_flash_model (
  input  wire logic               ref_clk,
  input  wire fcp_pkg::fcp_pins_t pins,
  input  wire logic [7:0]         dq_out,
  input  wire logic               vpp_low,
  output logic [7:0]              dq_in,
  output logic                    ready_busy
);
  logic [7:0] mem [16];
  logic [7:0] sr_q;
  logic [1:0] mode_q;
  logic       we_q;
  logic       ce_q;
  logic [7:0] last_q;
  int         busy_q;
  logic       drive;
  logic       strobe;
  logic [3:0] a;

  // A command counts only on a write strobe ending with select low.
  assign strobe = !ce_q && !we_q && pins.we_n;
  assign a      = pins.addr[3:0];
  assign drive  = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n;
  assign dq_in  = drive ? (mode_q == 2'd0 ? mem[a] : sr_q) : last_q;
  assign ready_busy = (busy_q == 0);

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    sr_q   = 8'h80;
    mode_q = 2'd0;
    busy_q = 0;
    last_q = 8'h00;
  end

  // Command interface, write state machine and status; the mode changes
  // only on host strobes and in powerdown.
  always @(posedge ref_clk) begin
    we_q   <= pins.we_n;
    ce_q   <= pins.ce_n;
    last_q <= drive ? dq_in : ~last_q;
    if (!pins.reset_powerdown_n) begin
      sr_q   <= 8'h80;
      mode_q <= 2'd0;
      busy_q <= 0;
    end else begin
      if (busy_q == 1) sr_q[7] <= 1'b1;
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (strobe) begin
        case (mode_q)
          2'd2: begin
            mode_q <= 2'd1;
            if (sr_q[3]) begin
            end else if (vpp_low) begin
              sr_q <= 8'h98;
            end else begin
              mem[a] <= mem[a] & dq_out;
              sr_q[7] <= 1'b0;
              busy_q  <= 20;
            end
          end
          2'd3: begin
            mode_q <= 2'd1;
            if (dq_out != 8'hd0) begin
              sr_q[5:4] <= 2'b11;
            end else if (sr_q[3]) begin
            end else if (vpp_low) begin
              sr_q <= 8'ha8;
            end else begin
              foreach (mem[i]) mem[i] <= 8'hff;
              sr_q[7] <= 1'b0;
              busy_q  <= 20;
            end
          end
          default: begin
            case (dq_out)
              8'hff: mode_q <= 2'd0;
              8'h70: mode_q <= 2'd1;
              8'h50: sr_q[5:3] <= 3'b000;
              8'h40: mode_q <= 2'd2;
              8'h20: mode_q <= 2'd3;
              default: mode_q <= mode_q;
            endcase
          end
        endcase
      end
    end
  end
endmodule

// *** sim/flash_command_status_protection_tb.sv ***
// Purpose: Self-checking bench for the flash command host.
// Assumes: Short wake and bus-phase counts keep the run brief.
// Notes:   Every operation is started over AHB-Lite; all but powerdown are polled.
`timescale 1ns/1ps
module flash_command_status_protection_tb;
  logic               ref_clk = 1'b0;
  logic               rst_n   = 1'b0;
  logic               hsel    = 1'b0;
  logic [31:0]        haddr   = 32'h0;
  logic [1:0]         htrans  = 2'b00;
  logic               hwrite  = 1'b0;
  logic [2:0]         hsize   = 3'b010;
  logic [31:0]        hwdata  = 32'h0;
  logic               hready;
  logic               hresp;
  logic [31:0]        hrdata;
  fcp_pkg::fcp_pins_t pins;
  logic [7:0]         dq_in;
  logic [7:0]         dq_out;
  logic               dq_oe;
  logic               ready_busy;
  logic               irq;
  logic               vpp_low = 1'b0;
  logic [31:0]        rd;
  int                 n_fail   = 0;
  int                 compares = 0;

  always #2 ref_clk = ~ref_clk;

  fcp_host #(.WAKE_RD(10), .WAKE_WR(10), .BUS_CYC(4)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .ready_busy(ready_busy), .irq(irq));

  fcp_flash_model flash_u (
    .ref_clk(ref_clk), .pins(pins), .dq_out(dq_out), .vpp_low(vpp_low),
    .dq_in(dq_in), .ready_busy(ready_busy));

  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single-word transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // Start an operation, wait for it to finish, return the status word.
  task automatic op(input int code, input logic [19:0] a,
                    input logic [7:0] d, output logic [31:0] st);
    int n;
    bus(1'b1, fcp_pkg::REG_ADDR, {12'h0, a}, st);
    bus(1'b1, fcp_pkg::REG_DATA, {24'h0, d}, st);
    bus(1'b1, fcp_pkg::REG_CTRL, 32'(code * 2 + 1), st);
    n = 0;
    do begin
      bus(1'b0, fcp_pkg::REG_CTRL, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 500);
    if (n >= 500) n_fail++;
    bus(1'b0, fcp_pkg::REG_STATUS, 32'h0, st);
  endtask

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, 8'h18, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, fcp_pkg::REG_MASK, 32'h3, rd);
    // Byte write, then read back through read-array mode.
    op(1, 20'h5, 8'ha5, rd);
    chk(rd, 32'h80);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    op(0, 20'h5, 8'h00, rd);
    chk(rd, 32'ha5);
    chk({24'h0, flash_u.mem[5]}, 32'ha5);
    // Erase returns the byte to its blank value.
    op(2, 20'h5, 8'h00, rd);
    chk(rd, 32'h80);
    op(0, 20'h5, 8'h00, rd);
    chk(rd, 32'hff);
    // Supply drop, refused retry, clear and repeat.
    vpp_low <= 1'b1;
    op(1, 20'h3, 8'h00, rd);
    chk(rd, 32'h98);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    chk(rd, 32'h3);
    vpp_low <= 1'b0;
    op(1, 20'h3, 8'h00, rd);
    chk(rd, 32'h98);
    op(0, 20'h3, 8'h00, rd);
    chk(rd, 32'hff);
    op(3, 20'h3, 8'h00, rd);
    chk({24'h0, flash_u.sr_q}, 32'h80);
    // Read status, then a bare return to array reads.
    op(5, 20'h3, 8'h00, rd);
    chk(rd, 32'h80);
    op(4, 20'h3, 8'h00, rd);
    chk(rd, 32'h80);
    chk({30'h0, flash_u.mode_q}, 32'h0);
    op(1, 20'h3, 8'h00, rd);
    chk(rd, 32'h80);
    // Masked completion keeps the line low but the event is kept.
    bus(1'b1, fcp_pkg::REG_MASK, 32'h0, rd);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    op(0, 20'h3, 8'h00, rd);
    chk(rd, 32'h00);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    chk(rd, 32'h1);
    bus(1'b0, fcp_pkg::REG_IRQ, 32'h0, rd);
    chk(rd, 32'h0);
    // Failed erase leaves error bits that powerdown must wipe.
    vpp_low <= 1'b1;
    op(2, 20'h3, 8'h00, rd);
    chk(rd, 32'ha8);
    vpp_low <= 1'b0;
    // Powerdown, then wake and read.
    bus(1'b1, fcp_pkg::REG_CTRL, 32'h11, rd);
    repeat (30) @(posedge ref_clk);
    chk({31'h0, pins.reset_powerdown_n}, 32'h0);
    chk({24'h0, flash_u.sr_q}, 32'h80);
    op(0, 20'h3, 8'h00, rd);
    chk(rd, 32'h00);
    print_verdict();
  end
endmodule
